/* rtl/clk_ctrl_pkg.sv */
// package: register map, field layout and reset values of the clock controller
// assumes: included before rtl/clock_controller_freq_divider.sv
package clk_ctrl_pkg;

    // ************************************************************
    // register byte offsets (one aligned word each)
    // ************************************************************
    localparam logic [7:0] PWR_CTRL_OFS = 8'h00;
    localparam logic [7:0] CLK_SEL_FIRST_OFS = 8'h04;
    localparam logic [7:0] PERIPH_EN_OFS = 8'h08;
    localparam logic [7:0] PERIPH_SRC_OFS = 8'h0C;
    localparam logic [7:0] PERIPH_DIV_OFS = 8'h10;
    localparam logic [7:0] DIV_CTRL_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PD_BIT = 0;
    localparam int SYS_SEL_LSB = 0;
    localparam int TICK_SEL_LSB = 3;
    localparam int SEL_W = 3;
    localparam int TAP_LSB = 0;
    localparam int TAP_W = 4;
    localparam int DIV_EN_BIT = 4;
    localparam int DIV_STAGES = 16;
    localparam int NUM_PERIPH = 8;
    localparam int PDIV_W = 4;

    // ************************************************************
    // source codes and reset values
    // ************************************************************
    localparam logic [2:0] SRC_XTAL_HI = 3'h0;
    localparam logic [2:0] SRC_XTAL_32K = 3'h1;
    localparam logic [2:0] SRC_PLL = 3'h2;
    localparam logic [2:0] SRC_LIRC_10K = 3'h3;
    localparam logic [2:0] SRC_HIRC = 3'h4;
    localparam logic [5:0] CLK_SEL_FIRST_RST = 6'h24;
    localparam logic [7:0] PERIPH_EN_RST = 8'h00;
    localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

    // peripherals allowed to run from a low-frequency source in power-down
    // bit order: watchdog, rtc, timer0..3, pwm, adc
    localparam logic [7:0] LF_CAPABLE = 8'hFF;

    typedef enum logic [2:0] {
        PM_RUN   = 3'b001,
        PM_ARMED = 3'b010,
        PM_DOWN  = 3'b100
    } pm_state_e;

endpackage

/* rtl/clock_controller_freq_divider.sv */
// clock controller: source select, peripheral gating, power-down, divider out
// assumes: a classic wishbone master on sys_clk_i; source clocks arrive as
// synchronous inputs, outputs are enables/selected levels from flip-flops
//
// Overview of operation
// - power-down only after control bit set, then wait-for-interrupt or event
// - power-down stops high crystal, internal oscillator, system and fast clocks
// - 10 kHz oscillator and 32 kHz crystal keep running in power-down
// - low-frequency-sourced watchdog, rtc, timers, pwm, adc clocks keep running
// - system clock source chosen by bits 2..0 of the first select register
// - tick clock source chosen by bits 5..3 of the first select register
// - each peripheral has on/off, source select and division factor
// - sixteen chained halving stages, one tap muxed onto output pin
// - output frequency equals input divided by two to the power N+1
// - rising edge of divider enable clears chain and starts counting
// - enable cleared: run until selected tap low, then hold low
module clock_controller_freq_divider
    import clk_ctrl_pkg::*;
#(
    parameter int NUM_PERIPH_P = NUM_PERIPH
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core sleep requests
    input wire logic wait_for_interrupt_instruction_i,
    input wire logic wait_for_event_instruction_i,
    input wire logic wake_i,
    // source clocks
    input wire logic [4:0] src_clk_i,
    input wire logic [4:0] periph_src_clk_i,
    // generated clocks and controls
    output logic sys_clk_o,
    output logic tick_timer_clock_o,
    output logic xtal_hi_en_o,
    output logic hirc_en_o,
    output logic xtal_32k_en_o,
    output logic lirc_en_o,
    output logic [NUM_PERIPH_P-1:0] periph_clk_o,
    output logic power_down_o,
    output logic divider_out_o
);

    // ************************************************************
    // registers
    // ************************************************************
    logic pd_bit_reg;
    logic [5:0] clock_select_first_reg;
    logic [NUM_PERIPH_P-1:0] periph_en_reg;
    logic [2*NUM_PERIPH_P-1:0] periph_src_reg;
    logic [PDIV_W*NUM_PERIPH_P-1:0] periph_div_reg;
    logic [TAP_W-1:0] divider_tap_select_reg;
    logic divider_output_enable_reg;
    pm_state_e pm_reg;
    logic [DIV_STAGES-1:0] chain_reg;
    logic div_run_reg;
    logic div_en_prev_reg;
    logic [SEL_W-1:0] sys_act_reg;
    logic [SEL_W-1:0] tick_act_reg;

    logic wb_req;
    logic [31:0] rd_data;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // ************************************************************
    // wishbone: one wait state, ack for every address
    // ************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
        end
    end

    always_comb begin
        rd_data = BAD_ADDR_DATA;
        unique case (wb_adr_i)
            PWR_CTRL_OFS: rd_data = 32'(pd_bit_reg);
            CLK_SEL_FIRST_OFS: rd_data = 32'(clock_select_first_reg);
            PERIPH_EN_OFS: rd_data = 32'(periph_en_reg);
            PERIPH_SRC_OFS: rd_data = 32'(periph_src_reg);
            PERIPH_DIV_OFS: rd_data = 32'(periph_div_reg);
            DIV_CTRL_OFS: rd_data = 32'({divider_output_enable_reg, divider_tap_select_reg});
            STATUS_OFS: rd_data = 32'({div_run_reg, tick_act_reg, sys_act_reg, pm_reg});
            default: rd_data = BAD_ADDR_DATA;
        endcase
    end

    // writes honour byte lane 0 for narrow fields, lanes 1..0 for peripheral sources, all lanes for peripheral dividers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pd_bit_reg <= 1'b0;
            clock_select_first_reg <= CLK_SEL_FIRST_RST;
            periph_en_reg <= '0;
            periph_src_reg <= '0;
            periph_div_reg <= '0;
            divider_tap_select_reg <= '0;
            divider_output_enable_reg <= 1'b0;
        end else if (wb_req && wb_we_i) begin
            unique case (wb_adr_i)
                PWR_CTRL_OFS: if (wb_sel_i[0]) pd_bit_reg <= wb_dat_i[PD_BIT];
                CLK_SEL_FIRST_OFS: if (wb_sel_i[0]) clock_select_first_reg <= wb_dat_i[5:0];
                PERIPH_EN_OFS: if (wb_sel_i[0]) periph_en_reg <= wb_dat_i[NUM_PERIPH_P-1:0];
                PERIPH_SRC_OFS: if (wb_sel_i[1:0] == 2'b11)
                    periph_src_reg <= wb_dat_i[2*NUM_PERIPH_P-1:0];
                PERIPH_DIV_OFS: if (&wb_sel_i)
                    periph_div_reg <= wb_dat_i[PDIV_W*NUM_PERIPH_P-1:0];
                DIV_CTRL_OFS: if (wb_sel_i[0]) begin
                    divider_tap_select_reg <= wb_dat_i[TAP_LSB +: TAP_W];
                    divider_output_enable_reg <= wb_dat_i[DIV_EN_BIT];
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // power-down sequencing
    // ************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pm_reg <= PM_RUN;
        end else begin
            unique case (pm_reg)
                PM_RUN: if (pd_bit_reg) pm_reg <= PM_ARMED;
                PM_ARMED: begin
                    if (!pd_bit_reg) begin
                        pm_reg <= PM_RUN;
                    end else if (wait_for_interrupt_instruction_i
                                 || wait_for_event_instruction_i) begin
                        pm_reg <= PM_DOWN;
                    end
                end
                PM_DOWN: if (wake_i) pm_reg <= PM_RUN;
                default: pm_reg <= PM_RUN;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_down_o <= 1'b0;
        end else begin
            power_down_o <= (pm_reg == PM_DOWN);
        end
    end

    // fast oscillators follow the state; the slow pair never stops
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            xtal_hi_en_o <= 1'b1;
            hirc_en_o <= 1'b1;
        end else begin
            xtal_hi_en_o <= (pm_reg != PM_DOWN);
            hirc_en_o <= (pm_reg != PM_DOWN);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            xtal_32k_en_o <= 1'b1;
            lirc_en_o <= 1'b1;
        end else begin
            xtal_32k_en_o <= 1'b1;
            lirc_en_o <= 1'b1;
        end
    end

    // ************************************************************
    // glitch-free source switch: change only while both clocks are low
    // ************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_act_reg <= CLK_SEL_FIRST_RST[SYS_SEL_LSB +: SEL_W];
        end else begin
            // a new source is taken only with old and new both low
            if (!src_clk_i[sys_act_reg]
                && !src_clk_i[clock_select_first_reg[SYS_SEL_LSB +: SEL_W]]
                && clock_select_first_reg[SYS_SEL_LSB +: SEL_W] <= SRC_HIRC) begin
                sys_act_reg <= clock_select_first_reg[SYS_SEL_LSB +: SEL_W];
            end
        end
    end

    // codes above the last source are ignored, the old source stays on
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_act_reg <= CLK_SEL_FIRST_RST[TICK_SEL_LSB +: SEL_W];
        end else begin
            // same rule as the system switch
            if (!src_clk_i[tick_act_reg]
                && !src_clk_i[clock_select_first_reg[TICK_SEL_LSB +: SEL_W]]
                && clock_select_first_reg[TICK_SEL_LSB +: SEL_W] <= SRC_HIRC) begin
                tick_act_reg <= clock_select_first_reg[TICK_SEL_LSB +: SEL_W];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_clk_o <= 1'b0;
        end else begin
            sys_clk_o <= src_clk_i[sys_act_reg] && (pm_reg != PM_DOWN);
        end
    end

    // tick clock is not gated here: its fast sources stop in power-down
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_timer_clock_o <= 1'b0;
        end else begin
            tick_timer_clock_o <= src_clk_i[tick_act_reg];
        end
    end

    // ************************************************************
    // per-peripheral gate, source and divider
    // ************************************************************
    for (genvar p = 0; p < NUM_PERIPH_P; p++) begin : g_periph
        logic [PDIV_W-1:0] cnt_reg;
        logic src_prev_reg;
        logic out_reg;
        logic src_lvl;
        logic low_freq;
        logic [1:0] sel;
        assign sel = periph_src_reg[2*p +: 2];
        // code 0 high crystal, 1 32 kHz, 2 hirc, 3 10 kHz
        assign src_lvl = periph_src_clk_i[sel];
        assign low_freq = (sel == 2'h1) || (sel == 2'h3);

        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                cnt_reg <= '0;
                src_prev_reg <= 1'b0;
                out_reg <= 1'b0;
            end else begin
                src_prev_reg <= src_lvl;
                if (!periph_en_reg[p]) begin
                    out_reg <= 1'b0;
                    cnt_reg <= '0;
                end else if ((pm_reg == PM_DOWN) && !(low_freq && LF_CAPABLE[p])) begin
                    out_reg <= 1'b0;
                end else if (src_lvl && !src_prev_reg) begin
                    // divide source edges by (factor + 1)
                    if (cnt_reg >= periph_div_reg[PDIV_W*p +: PDIV_W]) begin
                        cnt_reg <= '0;
                        out_reg <= !out_reg;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
            end
        end
        assign periph_clk_o[p] = out_reg;
    end

    // ************************************************************
    // power-of-two frequency divider
    // ************************************************************
    logic [DIV_STAGES-1:0] chain_next;
    logic tap_lvl;
    assign chain_next = chain_reg + 1'b1; // ripple of halving stages
    assign tap_lvl = chain_reg[divider_tap_select_reg]; // stage N gives fin/2^(N+1)

    // edge detector rests at the enable's reset level, so no false start
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_en_prev_reg <= 1'b0;
        end else begin
            div_en_prev_reg <= divider_output_enable_reg;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            chain_reg <= '0;
            div_run_reg <= 1'b0;
            divider_out_o <= 1'b0;
        end else begin
            if (divider_output_enable_reg && !div_en_prev_reg) begin
                chain_reg <= '0;
                div_run_reg <= 1'b1;
                divider_out_o <= 1'b0;
            end else if (div_run_reg) begin
                if (!divider_output_enable_reg && !tap_lvl) begin
                    div_run_reg <= 1'b0; // stop with tap low
                    divider_out_o <= 1'b0;
                end else begin
                    chain_reg <= chain_next;
                    divider_out_o <= chain_next[divider_tap_select_reg];
                end
            end
        end
    end

endmodule

/* dv/clock_controller_freq_divider_sva.sv */
// checker: bus handshake, power-down and source-switch assertions
// assumes: bound to clock_controller_freq_divider, one clock domain
module clock_controller_freq_divider_sva (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // sleep and clocks
    input wire logic wait_for_interrupt_instruction_i,
    input wire logic wait_for_event_instruction_i,
    input wire logic [4:0] src_clk_i,
    input wire logic sys_clk_o,
    input wire logic tick_timer_clock_o,
    input wire logic xtal_hi_en_o,
    input wire logic hirc_en_o,
    input wire logic xtal_32k_en_o,
    input wire logic lirc_en_o,
    input wire logic power_down_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic sleep_req;
    assign sleep_req = wait_for_interrupt_instruction_i || wait_for_event_instruction_i;
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_src_was_high;
        ($past(src_clk_i) != 5'h00) || ($past(src_clk_i, 2) != 5'h00);
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_UNMAPPED_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    AST_PD_CAUSE: assert property ($rose(power_down_o) |-> $past(sleep_req) ||
        $past(sleep_req, 2)) else $error("power-down without sleep request");
    AST_PD_STOPS: assert property (power_down_o && $past(power_down_o)
        |-> !xtal_hi_en_o && !hirc_en_o && !sys_clk_o) else $error("fast clock in power-down");
    AST_LF_RUN: assert property (xtal_32k_en_o && lirc_en_o)
        else $error("slow oscillator stopped");
    AST_SYS_CLEAN: assert property ($rose(sys_clk_o) |-> s_src_was_high)
        else $error("system clock rose with all sources low");
    AST_TICK_CLEAN: assert property ($rose(tick_timer_clock_o) |-> s_src_was_high)
        else $error("tick clock rose with all sources low");
endmodule

bind clock_controller_freq_divider clock_controller_freq_divider_sva chk (.sys_clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .wait_for_interrupt_instruction_i, .wait_for_event_instruction_i, .src_clk_i, .sys_clk_o,
    .tick_timer_clock_o, .xtal_hi_en_o, .hirc_en_o, .xtal_32k_en_o, .lirc_en_o, .power_down_o);

/* dv/osc_model.sv */
// partner: oscillator model feeding source levels to the clock controller
// assumes: counts on the system clock; a disabled oscillator holds low
module osc_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // oscillator enables
    input wire logic xtal_hi_en_i,
    input wire logic hirc_en_i,
    input wire logic xtal_32k_en_i,
    input wire logic lirc_en_i,
    // source levels
    output logic [4:0] src_clk_o,
    output logic [4:0] periph_src_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end
    // stopped oscillators go low, so a gated source cannot look alive
    assign src_clk_o = {hirc_en_i & cnt_reg[1], lirc_en_i & cnt_reg[5],
        (xtal_hi_en_i | hirc_en_i) & cnt_reg[2], xtal_32k_en_i & cnt_reg[4],
        xtal_hi_en_i & cnt_reg[0]};
    assign periph_src_clk_o = {1'h0, lirc_en_i & cnt_reg[5], hirc_en_i & cnt_reg[1],
        xtal_32k_en_i & cnt_reg[4], xtal_hi_en_i & cnt_reg[0]};
endmodule

/* dv/clock_controller_freq_divider_test.sv */
// testbench: register-driven checks of sources, divider and power-down
// assumes: package, design, checker and oscillator model compiled first
module clock_controller_freq_divider_test import clk_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wait_for_interrupt_instruction_i = 1'h0, wait_for_event_instruction_i = 1'h0;
    logic wake_i = 1'h0, wb_ack_o, sys_clk_o, tick_timer_clock_o, xtal_hi_en_o, hirc_en_o;
    logic xtal_32k_en_o, lirc_en_o, power_down_o, divider_out_o;
    logic [4:0] src_clk_i, periph_src_clk_i;
    logic [NUM_PERIPH-1:0] periph_clk_o;
    logic [3:0] taps[3] = '{4'h0, 4'h2, 4'h5};
    logic [3:0] lanes = 4'hF;
    int failures = 0, checked = 0, p, tg[5];
    always #5 sys_clk_i = ~sys_clk_i;
    clock_controller_freq_divider dut (.sys_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wait_for_interrupt_instruction_i,
        .wait_for_event_instruction_i, .wake_i, .src_clk_i, .periph_src_clk_i, .sys_clk_o,
        .tick_timer_clock_o, .xtal_hi_en_o, .hirc_en_o, .xtal_32k_en_o, .lirc_en_o,
        .periph_clk_o, .power_down_o, .divider_out_o);
    osc_model u_osc (.sys_clk_i, .rst_i, .xtal_hi_en_i(xtal_hi_en_o), .hirc_en_i(hirc_en_o),
        .xtal_32k_en_i(xtal_32k_en_o), .lirc_en_i(lirc_en_o), .src_clk_o(src_clk_i),
        .periph_src_clk_o(periph_src_clk_i));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one classic cycle; the watchdog bounds the wait for ack
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= lanes;
        @(posedge sys_clk_i);
        while (wb_ack_o !== 1'h1) @(posedge sys_clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask
    task automatic watch(input int n);
        logic [4:0] pv, cur;
        pv = {sys_clk_o, tick_timer_clock_o, periph_clk_o[2:0]};
        tg = '{0, 0, 0, 0, 0};
        repeat (n) begin
            @(posedge sys_clk_i);
            cur = {sys_clk_o, tick_timer_clock_o, periph_clk_o[2:0]};
            for (int i = 0; i < 5; i++) if (cur[i] !== pv[i]) tg[i]++;
            pv = cur;
        end
    endtask
    task automatic period(output int per);
        int t0, n;
        logic pv, cur;
        t0 = -1;
        per = 0;
        n = 0;
        pv = divider_out_o;
        while (per == 0 && n < 2000) begin
            @(posedge sys_clk_i);
            n++;
            cur = divider_out_o;
            if (cur === 1'h1 && pv === 1'h0) begin
                if (t0 >= 0) per = n - t0;
                t0 = n;
            end
            pv = cur;
        end
    endtask
    task automatic sleep_pulse(input logic wait_for_event_instruction);
        if (wait_for_event_instruction) wait_for_event_instruction_i <= 1'h1;
        else wait_for_interrupt_instruction_i <= 1'h1;
        repeat (2) @(posedge sys_clk_i);
        wait_for_event_instruction_i <= 1'h0;
        wait_for_interrupt_instruction_i <= 1'h0;
        repeat (3) @(posedge sys_clk_i);
    endtask
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        #100000;
        failures++;
        results();
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        bus(1'h0, CLK_SEL_FIRST_OFS, 32'h0);
        check("select reset", q, 32'h0000_0024);
        bus(1'h0, 8'h40, 32'h0);
        check("unmapped read", q, 32'h0);
        for (int c = 0; c < 5; c++) begin
            bus(1'h1, CLK_SEL_FIRST_OFS, {26'h0, c[2:0], c[2:0]});
            repeat (160) @(posedge sys_clk_i);
            bus(1'h0, STATUS_OFS, 32'h0);
            check("system source", q[5:3], c[2:0]);
            check("tick source", q[8:6], c[2:0]);
        end
        bus(1'h1, CLK_SEL_FIRST_OFS, 32'h3F);
        repeat (20) @(posedge sys_clk_i);
        bus(1'h0, STATUS_OFS, 32'h0);
        check("bad source code ignored", q[8:3], 6'h24);
        foreach (taps[k]) begin
            bus(1'h1, DIV_CTRL_OFS, {27'h0, 1'h1, taps[k]});
            period(p);
            check("divider period", p, 32'h1 << (taps[k] + 1));
            bus(1'h1, DIV_CTRL_OFS, {28'h0, taps[k]});
            repeat (70) @(posedge sys_clk_i);
            check("divider parked", divider_out_o, 1'h0);
            bus(1'h0, STATUS_OFS, 32'h0);
            check("divider stopped", q[9], 1'h0);
        end
        bus(1'h1, PERIPH_EN_OFS, 32'h3);
        bus(1'h1, PERIPH_SRC_OFS, 32'h1);
        watch(64);
        check("fast peripheral runs", tg[1] != 0, 1'h1);
        check("disabled peripheral idle", tg[2], 32'h0);
        check("system clock toggles", tg[4], 32'h20);
        check("tick clock toggles", tg[3], 32'h20);
        sleep_pulse(1'h0);
        check("no sleep unarmed", power_down_o, 1'h0);
        bus(1'h1, PWR_CTRL_OFS, 32'h1);
        bus(1'h0, STATUS_OFS, 32'h0);
        check("armed", q[2:0], 3'h2);
        sleep_pulse(1'h1);
        check("power down", power_down_o, 1'h1);
        check("fast clocks off", {xtal_hi_en_o, hirc_en_o, sys_clk_o}, 3'h0);
        check("slow oscillators on", {xtal_32k_en_o, lirc_en_o}, 2'h3);
        watch(64);
        check("slow peripheral runs", tg[0] != 0, 1'h1);
        check("fast peripheral stops", tg[1], 32'h0);
        check("system clock stopped", tg[4], 32'h0);
        check("tick clock stopped", tg[3], 32'h0);
        wake_i <= 1'h1;
        @(posedge sys_clk_i);
        wake_i <= 1'h0;
        repeat (3) @(posedge sys_clk_i);
        check("power down left", power_down_o, 1'h0);
        bus(1'h1, PWR_CTRL_OFS, 32'h0);
        lanes = 4'h7;
        bus(1'h1, PERIPH_DIV_OFS, 32'h10);
        lanes = 4'hF;
        bus(1'h0, PERIPH_DIV_OFS, 32'h0);
        check("narrow divider write ignored", q, 32'h0);
        bus(1'h1, PERIPH_DIV_OFS, 32'h10);
        bus(1'h1, PERIPH_SRC_OFS, 32'hB);
        repeat (16) @(posedge sys_clk_i);
        watch(64);
        check("divided peripheral rate", tg[1], 32'h8);
        check("10 kHz peripheral rate", tg[0], 32'h1);
        results();
    end
endmodule
